// ==== common/pmu_pkg.sv ====
// shared constants and types of the message unit
package pmu_pkg;

   // ---------------------------------------------------------------
   // widths and sizes
   // ---------------------------------------------------------------
   localparam int DATA_W      = 32;
   localparam int ADDR_W      = 8;
   localparam int FIFO_DEPTH  = 8;
   localparam int QPTR_W      = 4;

   // ---------------------------------------------------------------
   // remote (pci side) register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] H_IN_DOORBELL  = 8'h00;
   localparam logic [7:0] H_OUT_DOORBELL = 8'h04;
   localparam logic [7:0] H_IN_MSG0      = 8'h08;
   localparam logic [7:0] H_IN_MSG1      = 8'h0C;
   localparam logic [7:0] H_OUT_MSG0     = 8'h10;
   localparam logic [7:0] H_OUT_MSG1     = 8'h14;
   localparam logic [7:0] H_STATUS       = 8'h18;
   localparam logic [7:0] H_IN_POST0     = 8'h20;
   localparam logic [7:0] H_IN_POST1     = 8'h24;
   localparam logic [7:0] H_OUT_GET0     = 8'h28;
   localparam logic [7:0] H_OUT_GET1     = 8'h2C;

   // ---------------------------------------------------------------
   // local core register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] L_IN_DOORBELL  = 8'h00;
   localparam logic [7:0] L_OUT_DOORBELL = 8'h04;
   localparam logic [7:0] L_IN_MSG0      = 8'h08;
   localparam logic [7:0] L_IN_MSG1      = 8'h0C;
   localparam logic [7:0] L_OUT_MSG0     = 8'h10;
   localparam logic [7:0] L_OUT_MSG1     = 8'h14;
   localparam logic [7:0] L_STATUS       = 8'h18;
   localparam logic [3:0] L_QBASE_PAGE   = 4'h2;
   localparam logic [3:0] L_QHEAD_PAGE   = 4'h3;
   localparam logic [3:0] L_QTAIL_PAGE   = 4'h4;

   // ---------------------------------------------------------------
   // values after reset and fixed answers
   // ---------------------------------------------------------------
   localparam logic [31:0] REG_RESET  = 32'h0000_0000;
   localparam logic        INTA_IDLE  = 1'b1;
   localparam logic [31:0] EMPTY_WORD = 32'hFFFF_FFFF;
   localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WR   = 2'b01,
      ST_RD   = 2'b10
   } pmu_mem_state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } pmu_req_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pmu_mem_req_t;

   typedef struct packed {
      logic        queue;
      logic [31:0] data;
   } pmu_qent_t;

endpackage

// ==== design/pmu_msg_unit.sv ====
// message unit: doorbells, message registers and four ring queues
// Summary of operation
// - remote side sets inbound doorbell bits by writing ones over pci
// - any set inbound doorbell bit raises the core interrupt
// - core writing ones sets outbound doorbell bits and asserts inta
// - only host clears outbound doorbell bits by writing ones
// - remote write to either inbound message register interrupts the core
// - core write to either outbound message register asserts inta
// - interrupts leave as core line and pci line to the interrupt_ctrl
// - four ring queues live in local memory, two inbound, two outbound
// - inbound queues carry host to core, outbound core to host
// - unit moves queue entries between pci registers and local memory
// - new outbound entry interrupts host, new inbound entry interrupts core
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// fifo
// -------------------------------------------------------------------
module pmu_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // filling side
   input  wire logic             inValid,
   output var  logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output var  logic             outValid,
   input  wire logic             outReady,
   output var  logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wrPtr;
      logic [PW-1:0]               rdPtr;
      logic [PW:0]                 count;
   } pmu_fifo_state_t;

   pmu_fifo_state_t q;
   pmu_fifo_state_t d;
   logic            push;
   logic            pop;

   always_comb begin
      inReady  = (q.count != (PW+1)'(DEPTH));
      outValid = (q.count != '0);
      outData  = q.mem[q.rdPtr];
      push     = inValid && inReady;
      pop      = outValid && outReady;
      d        = q;
      if (push) begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr        = (q.wrPtr == PW'(DEPTH-1)) ? '0 : q.wrPtr + 1'b1;
      end
      if (pop) begin
         d.rdPtr = (q.rdPtr == PW'(DEPTH-1)) ? '0 : q.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         d.count = q.count + 1'b1;
      end else if (pop && !push) begin
         d.count = q.count - 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // pmu_fifo

// -------------------------------------------------------------------
// message unit top
// -------------------------------------------------------------------
module pmu_msg_unit #(
   parameter int QPW = pmu_pkg::QPTR_W
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset,
   // remote pci register port
   input  wire pmu_pkg::pmu_req_t    hostReq,
   output var  logic                 hostAck,
   output var  logic [31:0]          hostRdata,
   // local core register port
   input  wire pmu_pkg::pmu_req_t    localReq,
   output var  logic                 localAck,
   output var  logic [31:0]          localRdata,
   // local memory port
   output var  pmu_pkg::pmu_mem_req_t memReq,
   input  wire logic                 memAck,
   input  wire logic [31:0]          memRdata,
   // interrupt lines to the interrupt controller
   output var  logic                 coreIrq,
   output var  logic                 intaN
);
   import pmu_pkg::*;

   typedef struct packed {
      logic [31:0]           inDoorbell;
      logic [31:0]           outDoorbell;
      logic [1:0][31:0]      inMsg;
      logic [1:0][31:0]      outMsg;
      logic [1:0]            inMsgFlag;
      logic [1:0]            outMsgPend;
      logic [3:0][31:0]      qBase;
      logic [3:0][QPW-1:0]   qHead;
      logic [3:0][QPW-1:0]   qTail;
      pmu_mem_state_t        memState;
      logic                  memQ;
      pmu_mem_req_t          memReq;
      logic                  hostAck;
      logic [31:0]           hostRdata;
      logic                  localAck;
      logic [31:0]           localRdata;
      logic                  coreIrq;
      logic                  intaN;
   } pmu_state_t;

   function automatic logic [QPW-1:0] nextPtr(input logic [QPW-1:0] p);
      nextPtr = p + 1'b1;
   endfunction

   function automatic logic [31:0] slotAddr(input logic [31:0] base,
                                            input logic [QPW-1:0] p);
      slotAddr = base + (32'(p) << 2);
   endfunction

   pmu_state_t  q;
   pmu_state_t  d;
   logic [31:0] inDbSet;
   logic [31:0] inDbClr;
   logic [31:0] outDbSet;
   logic [31:0] outDbClr;
   logic [1:0]  inMsgSet;
   logic [1:0]  inMsgClr;
   logic [1:0]  outPendSet;
   logic [1:0]  outPendClr;
   logic        memStart;
   logic        hostTake;
   logic [1:0]  outIdx;
   logic        fifoInValid;
   logic        fifoInReady;
   pmu_qent_t   fifoInData;
   logic        fifoOutValid;
   logic        fifoOutReady;
   pmu_qent_t   fifoOutData;
   logic [1:0]  qSel;
   logic [1:0]  inIdx;

   // ---------------------------------------------------------------
   // staging fifo for posted inbound entries
   // ---------------------------------------------------------------
   pmu_fifo #(
      .WIDTH ($bits(pmu_qent_t)),
      .DEPTH (FIFO_DEPTH)
   ) postFifo (
      .clock    (clock),
      .reset    (reset),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoInData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   always_comb begin
      d            = q;
      d.hostAck    = 1'b0;
      d.localAck   = 1'b0;
      inDbSet      = '0;
      inDbClr      = '0;
      outDbSet     = '0;
      outDbClr     = '0;
      inMsgSet     = '0;
      inMsgClr     = '0;
      outPendSet   = '0;
      outPendClr   = '0;
      memStart     = 1'b0;
      fifoInValid  = 1'b0;
      fifoInData   = '{queue: hostReq.addr[2], data: hostReq.wdata};
      fifoOutReady = 1'b0;
      qSel         = localReq.addr[3:2];
      outIdx       = {1'b1, hostReq.addr[2]};
      inIdx        = {1'b0, fifoOutData.queue};
      hostTake     = hostReq.valid && !q.hostAck && (q.memState != ST_RD);

      // -------------------------------------------------------------
      // local core port, answered in one cycle
      // -------------------------------------------------------------
      if (localReq.valid && !q.localAck) begin
         d.localAck   = 1'b1;
         d.localRdata = READ_ZERO;
         if (localReq.write) begin
            case (localReq.addr)
               L_IN_DOORBELL:  inDbClr = localReq.wdata;
               L_OUT_DOORBELL: outDbSet = localReq.wdata;
               L_OUT_MSG0: begin
                  d.outMsg[0]   = localReq.wdata;
                  outPendSet[0] = 1'b1;
               end
               L_OUT_MSG1: begin
                  d.outMsg[1]   = localReq.wdata;
                  outPendSet[1] = 1'b1;
               end
               L_STATUS:       inMsgClr = localReq.wdata[1:0];
               default: begin
                  if (localReq.addr[7:4] == L_QBASE_PAGE) begin
                     d.qBase[qSel] = localReq.wdata;
                  end else if (localReq.addr[7:4] == L_QHEAD_PAGE
                               && qSel[1]) begin
                     d.qHead[qSel] = localReq.wdata[QPW-1:0];
                  end else if (localReq.addr[7:4] == L_QTAIL_PAGE
                               && !qSel[1]) begin
                     d.qTail[qSel] = localReq.wdata[QPW-1:0];
                  end
               end
            endcase
         end else begin
            case (localReq.addr)
               L_IN_DOORBELL:  d.localRdata = q.inDoorbell;
               L_OUT_DOORBELL: d.localRdata = q.outDoorbell;
               L_IN_MSG0:      d.localRdata = q.inMsg[0];
               L_IN_MSG1:      d.localRdata = q.inMsg[1];
               L_OUT_MSG0:     d.localRdata = q.outMsg[0];
               L_OUT_MSG1:     d.localRdata = q.outMsg[1];
               L_STATUS:       d.localRdata = {28'h0000000,
                                               q.outMsgPend, q.inMsgFlag};
               default: begin
                  if (localReq.addr[7:4] == L_QBASE_PAGE) begin
                     d.localRdata = q.qBase[qSel];
                  end else if (localReq.addr[7:4] == L_QHEAD_PAGE) begin
                     d.localRdata = 32'(q.qHead[qSel]);
                  end else if (localReq.addr[7:4] == L_QTAIL_PAGE) begin
                     d.localRdata = 32'(q.qTail[qSel]);
                  end
               end
            endcase
         end
      end

      // -------------------------------------------------------------
      // remote pci port
      // -------------------------------------------------------------
      if (hostTake) begin
         d.hostRdata = READ_ZERO;
         if (hostReq.write) begin
            d.hostAck = 1'b1;
            case (hostReq.addr)
               H_IN_DOORBELL:  inDbSet = hostReq.wdata;
               H_OUT_DOORBELL: outDbClr = hostReq.wdata;
               H_IN_MSG0: begin
                  d.inMsg[0]  = hostReq.wdata;
                  inMsgSet[0] = 1'b1;
               end
               H_IN_MSG1: begin
                  d.inMsg[1]  = hostReq.wdata;
                  inMsgSet[1] = 1'b1;
               end
               H_STATUS:       outPendClr = hostReq.wdata[1:0];
               H_IN_POST0, H_IN_POST1: begin
                  fifoInValid = 1'b1;
                  d.hostAck   = fifoInReady;
               end
               default:        d.hostAck = 1'b1;
            endcase
         end else begin
            d.hostAck = 1'b1;
            case (hostReq.addr)
               H_IN_DOORBELL:  d.hostRdata = q.inDoorbell;
               H_OUT_DOORBELL: d.hostRdata = q.outDoorbell;
               H_IN_MSG0:      d.hostRdata = q.inMsg[0];
               H_IN_MSG1:      d.hostRdata = q.inMsg[1];
               H_OUT_MSG0:     d.hostRdata = q.outMsg[0];
               H_OUT_MSG1:     d.hostRdata = q.outMsg[1];
               H_STATUS:       d.hostRdata = {30'h00000000, q.outMsgPend};
               H_OUT_GET0, H_OUT_GET1: begin
                  if (q.qHead[outIdx] == q.qTail[outIdx]) begin
                     d.hostRdata = EMPTY_WORD;
                  end else if (q.memState == ST_IDLE) begin
                     d.hostAck  = 1'b0;
                     memStart   = 1'b1;
                     d.memState = ST_RD;
                     d.memQ     = hostReq.addr[2];
                     d.memReq   = '{valid: 1'b1, write: 1'b0,
                                    addr: slotAddr(q.qBase[outIdx],
                                                   q.qTail[outIdx]),
                                    wdata: REG_RESET};
                  end else begin
                     d.hostAck = 1'b0;
                  end
               end
               default:        d.hostRdata = READ_ZERO;
            endcase
         end
      end

      // -------------------------------------------------------------
      // local memory mover
      // -------------------------------------------------------------
      case (q.memState)
         ST_IDLE: begin
            if (!memStart && fifoOutValid
                && nextPtr(q.qHead[inIdx]) != q.qTail[inIdx]) begin
               fifoOutReady = 1'b1;
               d.memState   = ST_WR;
               d.memQ       = fifoOutData.queue;
               d.memReq     = '{valid: 1'b1, write: 1'b1,
                                addr: slotAddr(q.qBase[inIdx],
                                               q.qHead[inIdx]),
                                wdata: fifoOutData.data};
            end
         end
         ST_WR: begin
            if (memAck) begin
               d.memReq.valid = 1'b0;
               d.memState     = ST_IDLE;
               d.qHead[{1'b0, q.memQ}] = nextPtr(q.qHead[{1'b0, q.memQ}]);
            end
         end
         ST_RD: begin
            if (memAck) begin
               d.memReq.valid = 1'b0;
               d.memState     = ST_IDLE;
               d.hostAck      = 1'b1;
               d.hostRdata    = memRdata;
               d.qTail[{1'b1, q.memQ}] = nextPtr(q.qTail[{1'b1, q.memQ}]);
            end
         end
         default: begin
            d.memState     = ST_IDLE;
            d.memReq.valid = 1'b0;
         end
      endcase

      // -------------------------------------------------------------
      // sticky flags, set beats clear
      // -------------------------------------------------------------
      d.inDoorbell  = (q.inDoorbell & ~inDbClr) | inDbSet;
      d.outDoorbell = (q.outDoorbell & ~outDbClr) | outDbSet;
      d.inMsgFlag   = (q.inMsgFlag & ~inMsgClr) | inMsgSet;
      d.outMsgPend  = (q.outMsgPend & ~outPendClr) | outPendSet;

      // -------------------------------------------------------------
      // interrupt lines
      // -------------------------------------------------------------
      d.coreIrq = (|d.inDoorbell) || (|d.inMsgFlag)
                  || (d.qHead[0] != d.qTail[0])
                  || (d.qHead[1] != d.qTail[1]);
      d.intaN   = !((|d.outDoorbell) || (|d.outMsgPend)
                    || (d.qHead[2] != d.qTail[2])
                    || (d.qHead[3] != d.qTail[3]));
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         q       <= '0;
         q.intaN <= INTA_IDLE;
      end else begin
         q <= d;
      end
   end

   assign hostAck    = q.hostAck;
   assign hostRdata  = q.hostRdata;
   assign localAck   = q.localAck;
   assign localRdata = q.localRdata;
   assign memReq     = q.memReq;
   assign coreIrq    = q.coreIrq;
   assign intaN      = q.intaN;
endmodule // pmu_msg_unit

`default_nettype wire

// ==== sim/pmu_mem_model.sv ====
// local memory model answering the message unit's memory port
`timescale 1ns/1ps
`default_nettype none
module pmu_mem_model (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  reset,
   // memory port
   input  wire pmu_pkg::pmu_mem_req_t memReq,
   output var  logic                  memAck,
   output var  logic [31:0]           memRdata,
   // answer speed
   input  wire logic                  slow
);
   import pmu_pkg::*;
   logic [31:0] mem [logic [31:0]];
   int          waitCnt;
   // rdata toggles outside the answer so stale data never matches
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         memAck   <= 1'b0;
         memRdata <= 32'h0000_0000;
         waitCnt  <= 0;
      end else begin
         memAck   <= 1'b0;
         memRdata <= ~memRdata;
         if (memReq.valid && !memAck) begin
            if (waitCnt > 0) begin
               waitCnt <= waitCnt - 1;
            end else begin
               memAck  <= 1'b1;
               waitCnt <= slow ? 3 : 0;
               if (memReq.write) mem[memReq.addr] = memReq.wdata;
               else memRdata <= mem.exists(memReq.addr) ?
                                mem[memReq.addr] : 32'h0000_0000;
            end
         end
      end
   end
endmodule // pmu_mem_model
`default_nettype wire

// ==== sim/pmu_msg_unit_chk.sv ====
// port assertions of the message unit
`timescale 1ns/1ps
`default_nettype none
module pmu_msg_unit_chk #(
   parameter int QPW = 4
) (
   // clock and reset
   input wire logic                  clock,
   input wire logic                  reset,
   // register ports
   input wire pmu_pkg::pmu_req_t     hostReq,
   input wire logic                  hostAck,
   input wire logic [31:0]           hostRdata,
   input wire pmu_pkg::pmu_req_t     localReq,
   input wire logic                  localAck,
   input wire logic [31:0]           localRdata,
   // memory and interrupts
   input wire pmu_pkg::pmu_mem_req_t memReq,
   input wire logic                  memAck,
   input wire logic [31:0]           memRdata,
   input wire logic                  coreIrq,
   input wire logic                  intaN
);
   import pmu_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   property p_local_ack;
      localReq.valid && !localAck |=> localAck ##1 !localAck;
   endproperty
   a_local_ack: assert property (p_local_ack) else $error("local ack late");
   property p_in_db;
      hostAck && hostReq.write && hostReq.addr == H_IN_DOORBELL
      && hostReq.wdata != 32'h0 |-> ##[0:2] coreIrq;
   endproperty
   a_in_db: assert property (p_in_db) else $error("no core irq on bell");
   property p_in_msg;
      hostAck && hostReq.write && (hostReq.addr == H_IN_MSG0
      || hostReq.addr == H_IN_MSG1) |-> ##[0:2] coreIrq;
   endproperty
   a_in_msg: assert property (p_in_msg) else $error("no core irq on msg");
   property p_out_db;
      localAck && localReq.write && localReq.addr == L_OUT_DOORBELL
      && localReq.wdata != 32'h0 |-> ##[0:2] !intaN;
   endproperty
   a_out_db: assert property (p_out_db) else $error("no inta on bell");
   property p_out_msg;
      localAck && localReq.write && (localReq.addr == L_OUT_MSG0
      || localReq.addr == L_OUT_MSG1) |-> ##[0:2] !intaN;
   endproperty
   a_out_msg: assert property (p_out_msg) else $error("no inta on msg");
   property p_inta_rel;
      $rose(intaN) |-> hostAck;
   endproperty
   a_inta_rel: assert property (p_inta_rel) else $error("inta freed");
   property p_irq_src;
      $rose(coreIrq) |-> hostAck || $past(memAck);
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("stray core irq");
   property p_mem_hold;
      memReq.valid && !memAck |=> $stable(memReq);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("mem req moved");
   property p_mem_drop;
      memAck |=> !memReq.valid;
   endproperty
   a_mem_drop: assert property (p_mem_drop) else $error("mem req kept");
   property p_get_data;
      memAck && !memReq.write |=> hostAck && hostRdata == $past(memRdata);
   endproperty
   a_get_data: assert property (p_get_data) else $error("get data lost");
   property p_read_bound;
      hostReq.valid && !hostReq.write && !hostAck |-> ##[1:40] hostAck;
   endproperty
   a_read_bound: assert property (p_read_bound) else $error("read hung");
endmodule // pmu_msg_unit_chk
bind pmu_msg_unit pmu_msg_unit_chk #(.QPW(QPW)) pmu_msg_unit_chk_inst (
   .clock(clock), .reset(reset), .hostReq(hostReq), .hostAck(hostAck),
   .hostRdata(hostRdata), .localReq(localReq), .localAck(localAck),
   .localRdata(localRdata), .memReq(memReq), .memAck(memAck),
   .memRdata(memRdata), .coreIrq(coreIrq), .intaN(intaN));
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench of the message unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pmu_pkg::*;
   logic         clock, reset, slow, coreIrq, intaN;
   logic         hostAck, localAck, memAck;
   logic [31:0]  hostRdata, localRdata, memRdata, rd, v, inDb, outDb;
   pmu_req_t     hostReq, localReq;
   pmu_mem_req_t memReq;
   int           error_cnt, n_checks, acks, seed, a0;
   logic [31:0]  expA[$], expD[$], words[$], base[4];
   pmu_msg_unit #(.QPW(4)) pmu_msg_unit_inst (.clock(clock), .reset(reset),
      .hostReq(hostReq), .hostAck(hostAck), .hostRdata(hostRdata),
      .localReq(localReq), .localAck(localAck), .localRdata(localRdata),
      .memReq(memReq), .memAck(memAck), .memRdata(memRdata),
      .coreIrq(coreIrq), .intaN(intaN));
   pmu_mem_model pmu_mem_model_inst (.clock(clock), .reset(reset),
      .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .slow(slow));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // ---------------------------------------------------------------
   // checks and bus cycles
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_irq(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t irq got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input bit h, input bit w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge clock);
      if (h) hostReq <= '{1'b1, w, a, d};
      else localReq <= '{1'b1, w, a, d};
      for (i = 0; i < 200; i++) begin
         @(posedge clock);
         if ((h ? hostAck : localAck) === 1'b1) break;
      end
      r = h ? hostRdata : localRdata;
      if (h) hostReq.valid <= 1'b0;
      else localReq.valid <= 1'b0;
      if (i == 200) begin
         error_cnt++;
         give_verdict;
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge clock);
   endtask
   always @(posedge clock) begin
      if (hostAck === 1'b1) acks++;
      if (!reset && memAck === 1'b1 && memReq.write === 1'b1) begin
         chk_reg(memReq.addr, expA.pop_front());
         chk_reg(memReq.wdata, expD.pop_front());
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h961C;
      reset = 1'b1;
      slow = 1'b0;
      hostReq = '0;
      localReq = '0;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         bus(0, 0, 8'(4 * k), 32'h0, rd);
         chk_reg(rd, REG_RESET);
      end
      chk_irq(coreIrq, 1'b0);
      chk_irq(intaN, INTA_IDLE);
      $display("test reset done");
      inDb = 32'h0;
      repeat (2) begin
         v = $random(seed) | 32'h1;
         inDb |= v;
         bus(1, 1, H_IN_DOORBELL, v, rd);
      end
      bus(0, 0, L_IN_DOORBELL, 32'h0, rd);
      chk_reg(rd, inDb);
      settle;
      chk_irq(coreIrq, 1'b1);
      v = $random(seed);
      inDb &= ~v;
      bus(0, 1, L_IN_DOORBELL, v, rd);
      bus(1, 0, H_IN_DOORBELL, 32'h0, rd);
      chk_reg(rd, inDb);
      bus(0, 1, L_IN_DOORBELL, inDb, rd);
      settle;
      chk_irq(coreIrq, 1'b0);
      outDb = $random(seed) | 32'h3;
      bus(0, 1, L_OUT_DOORBELL, outDb, rd);
      settle;
      chk_irq(intaN, 1'b0);
      bus(1, 1, H_OUT_DOORBELL, 32'h1, rd);
      outDb &= ~32'h1;
      bus(0, 0, L_OUT_DOORBELL, 32'h0, rd);
      chk_reg(rd, outDb);
      settle;
      chk_irq(intaN, 1'b0);
      bus(1, 1, H_OUT_DOORBELL, outDb, rd);
      settle;
      chk_irq(intaN, 1'b1);
      $display("test doorbells done");
      for (int k = 0; k < 2; k++) begin
         v = $random(seed);
         bus(1, 1, H_IN_MSG0 + 8'(4 * k), v, rd);
         bus(0, 0, L_IN_MSG0 + 8'(4 * k), 32'h0, rd);
         chk_reg(rd, v);
         settle;
         chk_irq(coreIrq, 1'b1);
         bus(0, 1, L_STATUS, 32'h3, rd);
         settle;
         chk_irq(coreIrq, 1'b0);
         v = $random(seed);
         bus(0, 1, L_OUT_MSG0 + 8'(4 * k), v, rd);
         bus(1, 0, H_OUT_MSG0 + 8'(4 * k), 32'h0, rd);
         chk_reg(rd, v);
         settle;
         chk_irq(intaN, 1'b0);
         bus(1, 1, H_STATUS, 32'h3, rd);
         settle;
         chk_irq(intaN, 1'b1);
      end
      $display("test messages done");
      for (int q = 0; q < 4; q++) begin
         base[q] = 32'h1000 * (q + 1);
         bus(0, 1, {L_QBASE_PAGE, 4'(4 * q)}, base[q], rd);
      end
      slow <= 1'b1;
      for (int k = 0; k < 24; k++) begin
         v = $random(seed);
         expA.push_back(base[0] + 32'(4 * (k % 16)));
         expD.push_back(v);
         if (k < 23) bus(1, 1, H_IN_POST0, v, rd);
      end
      repeat (60) @(posedge clock);
      bus(0, 0, {L_QHEAD_PAGE, 4'h0}, 32'h0, rd);
      chk_reg(rd, 32'd15);
      chk_irq(coreIrq, 1'b1);
      fork
         bus(1, 1, H_IN_POST0, v, rd);
         begin
            a0 = acks;
            repeat (30) @(posedge clock);
            chk_reg(32'(acks), 32'(a0));
            bus(0, 1, {L_QTAIL_PAGE, 4'h0}, 32'd15, rd);
         end
      join
      expA.push_back(base[1]);
      expD.push_back(v);
      bus(1, 1, H_IN_POST1, v, rd);
      repeat (80) @(posedge clock);
      chk_reg(32'(expA.size()), 32'h0);
      bus(0, 0, {L_QHEAD_PAGE, 4'h0}, 32'h0, rd);
      chk_reg(rd, 32'd8);
      bus(0, 1, {L_QTAIL_PAGE, 4'h0}, 32'd8, rd);
      bus(0, 1, {L_QTAIL_PAGE, 4'h4}, 32'd1, rd);
      settle;
      chk_irq(coreIrq, 1'b0);
      $display("test inbound queue done");
      for (int q = 0; q < 2; q++) begin
         slow <= q[0];
         words.delete();
         for (int k = 0; k < 3; k++) begin
            words.push_back($random(seed));
            pmu_mem_model_inst.mem[base[2 + q] + 32'(4 * k)] = words[k];
         end
         bus(0, 1, {L_QHEAD_PAGE, 4'(8 + 4 * q)}, 32'd3, rd);
         settle;
         chk_irq(intaN, 1'b0);
         for (int k = 0; k < 3; k++) begin
            bus(1, 0, H_OUT_GET0 + 8'(4 * q), 32'h0, rd);
            chk_reg(rd, words[k]);
         end
         bus(1, 0, H_OUT_GET0 + 8'(4 * q), 32'h0, rd);
         chk_reg(rd, EMPTY_WORD);
         settle;
         chk_irq(intaN, 1'b1);
      end
      $display("test outbound queues done");
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
